// ### hw/dbg_seq_pkg.sv
// Package with state-sequencer types and constants
package dbg_seq_pkg;

  // ********************
  // Sequencer states
  // ********************
  typedef enum logic [1:0] {
    SEQ_STATE1,
    SEQ_STATE2,
    SEQ_STATE3,
    SEQ_FINAL
  } seq_state_e;

  // ********************
  // Widths and fields
  // ********************
  localparam int unsigned NUM_CH      = 3;
  localparam int unsigned CTRL_W      = 4;
  localparam int unsigned CTRL_EXT_BIT = 3;
  localparam int unsigned QUEUE_DEPTH = 4;

  // Reset values of the state-control encodings
  localparam logic [3:0] STATE_CTRL_RST = 4'h0;

  // Per-channel comparator configuration
  typedef struct packed {
    logic enable;
    logic tagMode;    // 1: tag opcode, 0: act immediately
  } comp_cfg_s;

  // Sequencer configuration bundle
  typedef struct packed {
    logic [3:0]      state1Control;
    logic [3:0]      state2Control;
    logic [3:0]      state3Control;
    comp_cfg_s [2:0] comparator;
    logic            rangeMode;     // comparator_a/_b as range
    logic            breakEnable;
  } seq_cfg_s;

  // Raw comparator events per channel
  typedef struct packed {
    logic [2:0] match;    // match_ch2..match_ch0
    logic       fetch;    // Opcode enters queue
    logic       advance;  // Queue head executes
  } comp_evt_s;

endpackage

// ### hw/tag_queue.sv
// Tag shift queue travelling beside the instruction queue
`timescale 1ns/1ps
module tag_queue (
  input  wire logic                                    clk,
  input  wire logic                                    rstN,
  input  wire logic                                    flush,
  input  wire logic                                    fetch,
  input  wire logic                                    advance,
  input  wire logic [dbg_seq_pkg::NUM_CH-1:0]          tagIn,
  output logic      [dbg_seq_pkg::NUM_CH-1:0]          tagHit
);

  typedef struct packed {
    logic [dbg_seq_pkg::QUEUE_DEPTH-1:0][dbg_seq_pkg::NUM_CH-1:0] slot;
    logic [2:0]                                             count;
    logic [dbg_seq_pkg::NUM_CH-1:0]                         hit;
  } tq_s;

  tq_s state_q;
  tq_s state_d;

  // ********************
  // Queue movement
  // ********************
  always_comb
  begin
    state_d     = state_q;
    state_d.hit = '0;
    if (flush)
    begin
      state_d = '0;
    end
    else
    begin
      if (advance && state_q.count != 3'h0)
      begin
        state_d.hit = state_q.slot[0];  // Hit only at queue head [RULE_08]
        for (int i = 0; i < dbg_seq_pkg::QUEUE_DEPTH - 1; i++)
        begin
          state_d.slot[i] = state_q.slot[i+1];
        end
        state_d.slot[dbg_seq_pkg::QUEUE_DEPTH-1] = '0;
        state_d.count = state_q.count - 3'h1;
      end
      if (fetch && state_d.count != 3'(dbg_seq_pkg::QUEUE_DEPTH))
      begin
        state_d.slot[state_d.count[1:0]] = tagIn;  // Tag rides opcode [RULE_08]
        state_d.count = state_d.count + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign tagHit = state_q.hit;

endmodule

// ### hw/debug_state_sequencer.sv
// Debug state sequencer with three comparator channels
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Simultaneous hits: one leading to Final State wins.
// RULE_02: Otherwise the lowest-numbered channel's hit wins.
// RULE_03: State controls are four bits; low three keep old meaning.
// RULE_04: In range mode, channel 1 matches are ignored.
// RULE_05: Range and data comparisons exist on channel 0 only.
// RULE_06: Extended State3 code: ch0 back to State2, ch2 to Final.
// RULE_07: Extended State1 code: ch0 goes straight to State3.
// RULE_08: Tags ride opcodes; hit only at queue head.
// RULE_09: Per-comparator tag bit picks immediate or tagged action.
// RULE_10: Entering Final State can request a breakpoint.
// RULE_11: At Final State raise trigger, ignore events until rearmed.
module debug_state_sequencer (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    arm,
  input  wire dbg_seq_pkg::seq_cfg_s   cfg,
  input  wire dbg_seq_pkg::comp_evt_s  evt,
  input  wire logic                    dataMatch,
  input  wire logic                    inRange,
  input  wire logic                    bdmActive,
  output logic                         trigger,
  output logic                         breakReq,
  output dbg_seq_pkg::seq_state_e      seqState
);

  // ********************
  // Reset release
  // ********************
  logic [1:0] rstSync_q;
  logic       rstN;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];

  // ********************
  // Next-state lookup
  // ********************
  // Returns 1 in [2] when channel moves, target in [1:0]
  function automatic logic [2:0] nextOf(
    input dbg_seq_pkg::seq_state_e cur,
    input logic [3:0]              ctl,
    input int unsigned             ch
  );
    logic [2:0] r;
    r = 3'b000;
    case (cur)
      dbg_seq_pkg::SEQ_STATE1:
      begin
        if (ctl[dbg_seq_pkg::CTRL_EXT_BIT])
        begin
          // Extended: ch0 to State3, ch1 Final, ch2 State2 [RULE_07]
          if (ch == 0) r = {1'b1, 2'(dbg_seq_pkg::SEQ_STATE3)};
          if (ch == 1) r = {1'b1, 2'(dbg_seq_pkg::SEQ_FINAL)};
          if (ch == 2) r = {1'b1, 2'(dbg_seq_pkg::SEQ_STATE2)};
        end
        else if (ctl[2:0] == 3'(ch) || ctl[2:0] == 3'h7)
          r = {1'b1, 2'(dbg_seq_pkg::SEQ_STATE2)};  // Legacy code [RULE_03]
        else if (ctl[2:0] == 3'(ch + 3))
          r = {1'b1, 2'(dbg_seq_pkg::SEQ_STATE3)};
      end
      dbg_seq_pkg::SEQ_STATE2:
      begin
        if (ctl[dbg_seq_pkg::CTRL_EXT_BIT])
        begin
          // Extended OR fork: ch2 Final, ch0/ch1 back to State1
          if (ch == 2) r = {1'b1, 2'(dbg_seq_pkg::SEQ_FINAL)};
          else         r = {1'b1, 2'(dbg_seq_pkg::SEQ_STATE1)};
        end
        else if (ctl[2:0] == 3'(ch) || ctl[2:0] == 3'h7)
          r = {1'b1, 2'(dbg_seq_pkg::SEQ_STATE3)};  // [RULE_03]
        else if (ctl[2:0] == 3'(ch + 3))
          r = {1'b1, 2'(dbg_seq_pkg::SEQ_FINAL)};
      end
      dbg_seq_pkg::SEQ_STATE3:
      begin
        if (ctl[dbg_seq_pkg::CTRL_EXT_BIT])
        begin
          // Extended: ch0 back to State2, ch2 to Final [RULE_06]
          if (ch == 0) r = {1'b1, 2'(dbg_seq_pkg::SEQ_STATE2)};
          if (ch == 2) r = {1'b1, 2'(dbg_seq_pkg::SEQ_FINAL)};
        end
        else if (ctl[2:0] == 3'(ch) || ctl[2:0] == 3'h7)
          r = {1'b1, 2'(dbg_seq_pkg::SEQ_FINAL)};  // [RULE_03]
        else if (ctl[2:0] == 3'(ch + 3))
          r = {1'b1, 2'(dbg_seq_pkg::SEQ_STATE1)};
      end
      default:
        r = 3'b000;
    endcase
    return r;
  endfunction

  // ********************
  // Channel event qualification
  // ********************
  logic [2:0] rawMatch;
  logic [2:0] tagIn;
  logic [2:0] tagHit;
  logic [2:0] immHit;
  logic [2:0] chEvent;
  logic       tagFlush;

  always_comb
  begin
    rawMatch = evt.match;
    // Channel 0 alone sees range and data qualification [RULE_05]
    if (cfg.rangeMode)
      rawMatch[0] = inRange && cfg.comparator[0].enable;
    else
      rawMatch[0] = evt.match[0] && dataMatch;
    if (cfg.rangeMode)
      rawMatch[1] = 1'b0;  // Channel 1 silenced in range mode [RULE_04]
    for (int c = 0; c < dbg_seq_pkg::NUM_CH; c++)
    begin
      rawMatch[c] = rawMatch[c] && cfg.comparator[c].enable && !bdmActive;
      // Tag bit picks tagging or immediate action [RULE_09]
      tagIn[c]  = rawMatch[c] && cfg.comparator[c].tagMode && evt.fetch;
      immHit[c] = rawMatch[c] && !cfg.comparator[c].tagMode;
    end
  end

  // Tags dropped while disarmed or in debug mode
  assign tagFlush = bdmActive || !arm;

  tag_queue tagQueue (
    .clk     (clk),
    .rstN    (rstN),
    .flush   (tagFlush),
    .fetch   (evt.fetch),
    .advance (evt.advance),
    .tagIn   (tagIn),
    .tagHit  (tagHit)
  );

  assign chEvent = immHit | (tagHit & {3{!bdmActive}});

  // ********************
  // Sequencer state
  // ********************
  typedef struct packed {
    dbg_seq_pkg::seq_state_e state;
    logic                    trig;
    logic                    brk;
  } seq_s;

  seq_s state_q;
  seq_s state_d;

  always_comb
  begin
    logic [3:0]  ctl;
    logic [2:0]  nx;
    logic        taken;
    logic [1:0]  target;
    ctl    = 4'h0;
    nx     = 3'b000;
    taken  = 1'b0;
    target = 2'b00;
    state_d     = state_q;
    state_d.brk = 1'b0;
    case (state_q.state)
      dbg_seq_pkg::SEQ_STATE1: ctl = cfg.state1Control;
      dbg_seq_pkg::SEQ_STATE2: ctl = cfg.state2Control;
      dbg_seq_pkg::SEQ_STATE3: ctl = cfg.state3Control;
      default:                 ctl = dbg_seq_pkg::STATE_CTRL_RST;
    endcase
    // Highest channel first, so the lowest wins; a Final target overrides [RULE_02]
    for (int c = dbg_seq_pkg::NUM_CH - 1; c >= 0; c--)
    begin
      nx = nextOf(state_q.state, ctl, unsigned'(c));
      if (chEvent[c] && nx[2])
      begin
        if (!(taken && target == 2'(dbg_seq_pkg::SEQ_FINAL)) ||
            nx[1:0] == 2'(dbg_seq_pkg::SEQ_FINAL))
        begin
          taken  = 1'b1;
          target = nx[1:0];  // [RULE_01]
        end
      end
    end
    if (!arm)
    begin
      state_d.state = dbg_seq_pkg::SEQ_STATE1;
      state_d.trig  = 1'b0;
    end
    else if (state_q.state == dbg_seq_pkg::SEQ_FINAL)
    begin
      state_d.trig = 1'b1;  // Hold, ignore channels [RULE_11]
    end
    else if (taken)
    begin
      state_d.state = dbg_seq_pkg::seq_state_e'(target);
      if (target == 2'(dbg_seq_pkg::SEQ_FINAL))
      begin
        state_d.trig = 1'b1;  // [RULE_11]
        state_d.brk  = cfg.breakEnable;  // [RULE_10]
      end
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      state_q <= '{state: dbg_seq_pkg::SEQ_STATE1, trig: 1'b0, brk: 1'b0};
    else
      state_q <= state_d;
  end

  assign trigger  = state_q.trig;
  assign breakReq = state_q.brk;
  assign seqState = state_q.state;

endmodule

// ### verif/debug_state_sequencer_props.sv
// Assertions on the debug state sequencer ports
`timescale 1ns/1ps
module debug_state_sequencer_props (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    arm,
  input wire dbg_seq_pkg::seq_cfg_s   cfg,
  input wire dbg_seq_pkg::comp_evt_s  evt,
  input wire logic                    dataMatch,
  input wire logic                    inRange,
  input wire logic                    bdmActive,
  input wire logic                    trigger,
  input wire logic                    breakReq,
  input wire dbg_seq_pkg::seq_state_e seqState
);
  logic tagSeen_q;
  logic imm;
  // Tags may sit in the queue once any comparator is in tag mode while armed
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      tagSeen_q <= 1'b0;
    else if (!arm || bdmActive)
      tagSeen_q <= 1'b0;
    else if (cfg.comparator[0].tagMode || cfg.comparator[1].tagMode
             || cfg.comparator[2].tagMode)
      tagSeen_q <= 1'b1;
  // Armed, immediate mode, no tag hit pending
  assign imm = arm && !bdmActive && !tagSeen_q && dataMatch
               && cfg.comparator == 6'h2a;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_trig; trigger == (seqState == 2'h3); endproperty
  a_trig: assert property (p_trig) else $error("trigger off state");
  property p_hold; arm && seqState == 2'h3 |=> seqState == 2'h3; endproperty
  a_hold: assert property (p_hold) else $error("final left");
  property p_brk; breakReq |-> $rose(trigger); endproperty
  a_brk: assert property (p_brk) else $error("stray break");
  property p_disarm; !arm |=> seqState == 2'h0 && !trigger; endproperty
  a_disarm: assert property (p_disarm) else $error("no disarm");
  property p_ch1;
    imm && cfg.rangeMode && !inRange && evt.match == 3'h2 |=> $stable(seqState);
  endproperty
  a_ch1: assert property (p_ch1) else $error("ch1 in range");
  property p_rng;
    imm && cfg.rangeMode && inRange && seqState == 2'h0
    && cfg.state1Control == 4'h0 && !evt.match[2] |=> seqState == 2'h1;
  endproperty
  a_rng: assert property (p_rng) else $error("range ch0");
  property p_leg;
    imm && !cfg.rangeMode && seqState == 2'h0 && cfg.state1Control == 4'h3
    && evt.match == 3'h1 |=> seqState == 2'h2;
  endproperty
  a_leg: assert property (p_leg) else $error("legacy skip");
  property p_s3;
    imm && !cfg.rangeMode && seqState == 2'h2 && cfg.state3Control == 4'h8
    && evt.match[0] |=> seqState == ($past(evt.match[2]) ? 2'h3 : 2'h1);
  endproperty
  a_s3: assert property (p_s3) else $error("state3 fork");
  property p_s1;
    imm && !cfg.rangeMode && seqState == 2'h0 && cfg.state1Control == 4'h8
    && evt.match[0] && !evt.match[1] |=> seqState == 2'h2;
  endproperty
  a_s1: assert property (p_s1) else $error("state1 jump");
  c_brk: cover property (breakReq);
  c_s3: cover property (seqState == 2'h2 ##1 seqState == 2'h3);
  c_ch1: cover property (imm && cfg.rangeMode && evt.match == 3'h2);
endmodule
bind debug_state_sequencer debug_state_sequencer_props
  debug_state_sequencer_props_i (.clk, .rst_n, .arm, .cfg, .evt, .dataMatch,
  .inRange, .bdmActive, .trigger, .breakReq, .seqState);

// ### verif/queue_model.sv
// Instruction queue and comparator event model
`timescale 1ns/1ps
module queue_model (
  input  wire logic              clk,
  input  wire logic [2:0]        hitReq,
  output dbg_seq_pkg::comp_evt_s evt
);
  logic [1:0] pipeQ;
  initial
  begin
    evt = '0;
    pipeQ = 2'h0;
  end
  // Opcode fetched with its match, at head two cycles on
  always @(negedge clk)
  begin
    evt.match <= hitReq;
    evt.fetch <= |hitReq;
    pipeQ <= {pipeQ[0], |hitReq};
    evt.advance <= pipeQ[1];
  end
endmodule

// ### verif/testbench.sv
// Self-checking testbench for the debug state sequencer
`timescale 1ns/1ps
module testbench;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    arm = 1'b0;
  dbg_seq_pkg::seq_cfg_s   cfg = '0;
  dbg_seq_pkg::comp_evt_s  evt;
  logic                    dataMatch = 1'b1;
  logic                    inRange = 1'b0;
  logic                    bdmActive = 1'b0;
  logic                    trigger;
  logic                    breakReq;
  dbg_seq_pkg::seq_state_e seqState;
  logic [2:0]              hitReq = 3'h0;
  logic [11:0]             ctl;
  logic [1:0]              st;
  logic [31:0]             r;
  int                      fail_count = 0;
  int                      n_compared = 0;
  int                      cyc = 0;
  int                      seed = 32'h0000_8e5f;
  always #2 clk = ~clk;
  debug_state_sequencer debug_state_sequencer_i (.clk, .rst_n, .arm, .cfg,
    .evt, .dataMatch, .inRange, .bdmActive, .trigger, .breakReq, .seqState);
  queue_model queue_model_i (.clk, .hitReq, .evt);
  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [2:0] tg(logic [1:0] s, logic [3:0] c, int ch);
    if (c[3])
      case (s)
        2'h0: return {1'b1, ch == 0 ? 2'h2 : ch == 1 ? 2'h3 : 2'h1};
        2'h1: return {1'b1, ch == 2 ? 2'h3 : 2'h0};
        default: return {ch != 1, ch == 0 ? 2'h1 : 2'h3};
      endcase
    if (c[2:0] == ch || c[2:0] == 7)
      return {1'b1, s + 2'h1};
    if (c[2:0] == ch + 3)
      return {1'b1, s == 2'h0 ? 2'h2 : s == 2'h1 ? 2'h3 : 2'h0};
    return 3'h0;
  endfunction
  function automatic logic [1:0] nxt(logic [1:0] s, logic [2:0] q);
    logic [2:0] t;
    logic [1:0] n;
    logic       f;
    n = s;
    f = 1'b0;
    for (int ch = 2; ch >= 0 && s != 2'h3; ch--)
    begin
      t = tg(s, ctl[4*s +: 4], ch);
      if (q[ch] && t[2])
      begin
        n = t[1:0];
        f |= t[1:0] == 2'h3;
      end
    end
    return f ? 2'h3 : n;
  endfunction
  task automatic ev(input logic [2:0] m, input logic ir, input logic bd);
    logic [1:0] e;
    logic [2:0] q;
    @(negedge clk) hitReq <= m;
    @(negedge clk) hitReq <= 3'h0;
    inRange <= ir;
    bdmActive <= bd;
    q = {m[2], m[1] & !cfg.rangeMode, cfg.rangeMode ? ir : m[0] & dataMatch};
    e = nxt(st, q & {3{!bd}});
    @(negedge clk) bdmActive <= 1'b0;
    inRange <= 1'b0;
    chk("state", e, seqState);
    chk("trigbrk", {e == 2'h3, e == 2'h3 && st != 2'h3 && cfg.breakEnable},
        {trigger, breakReq});
    st = e;
  endtask
  task automatic tc(input logic [11:0] c, input logic rg, input logic be,
                    input logic [8:0] ms, input logic [2:0] irs,
                    input logic [2:0] bds);
    @(negedge clk) arm <= 1'b0;
    cfg <= {c[3:0], c[7:4], c[11:8], 6'h2a, rg, be};
    ctl = c;
    @(negedge clk) arm <= 1'b1;
    chk("disarm", 2'h0, seqState);
    st = 2'h0;
    for (int i = 0; i < 3; i++)
      ev(ms[3*i +: 3], irs[i], bds[i]);
    $display("test ctl %h done", c);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    tc(12'h808, 1'b0, 1'b1, 9'h029, 3'h0, 3'h0);
    rst_n = 1'b0;
    @(negedge clk) chk("rstout", 2'h0, {trigger, breakReq});
    chk("rststate", 2'h0, seqState);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    $display("test reset done");
    tc(12'h808, 1'b0, 1'b0, 9'h005, 3'h0, 3'h0);
    tc(12'h808, 1'b0, 1'b0, 9'h009, 3'h0, 3'h0);
    tc(12'h003, 1'b0, 1'b1, 9'h001, 3'h0, 3'h1);
    tc(12'h003, 1'b0, 1'b1, 9'h001, 3'h0, 3'h0);
    tc(12'h000, 1'b1, 1'b0, 9'h002, 3'h2, 3'h0);
    @(negedge clk) arm <= 1'b0;
    cfg <= {12'h000, 6'h2b, 1'b0, 1'b0};
    @(negedge clk) arm <= 1'b1;
    hitReq <= 3'h1;
    @(negedge clk) hitReq <= 3'h0;
    @(negedge clk) chk("tagwait", 2'h0, seqState);
    repeat (2) @(negedge clk);
    chk("taghead", 2'h0, seqState);
    @(negedge clk) chk("taghit", 2'h1, seqState);
    $display("test tag done");
    repeat (40)
    begin
      r = $random(seed);
      dataMatch = r[27];
      tc(r[11:0], r[12], r[13], r[22:14], r[25:23], r[30:28] & {3{r[26]}});
    end
    print_verdict();
  end
endmodule
